//--- core/acfg_defines.svh
`ifndef ACFG_DEFINES_SVH
`define ACFG_DEFINES_SVH

// Register indices; byte address is four times the index
`define ACFG_IDX_CONFIG_A 8'h6B
`define ACFG_IDX_CONFIG_B 8'h6C
`define ACFG_IDX_VOL_BASE 8'h80
`define ACFG_IDX_STATUS 8'h88
`define ACFG_IDX_APPLIED_BASE 8'h90

// Reset values
`define ACFG_RST_CONFIG_A 8'h01
`define ACFG_RST_CONFIG_B 8'h40
`define ACFG_RST_VOLUME 8'hC9

// Processing configuration A field positions
`define ACFG_A_LOCK 7
`define ACFG_A_RSV 6
`define ACFG_A_DECIM_LSB 4
`define ACFG_A_AVG_LSB 2
`define ACFG_A_HPF_LSB 0

// Processing configuration B field positions
`define ACFG_B_GANG 7
`define ACFG_B_BIQ_LSB 5
`define ACFG_B_SOFT_DIS 4
`define ACFG_B_AGC 3
`define ACFG_B_RSV2 2
`define ACFG_B_RSV1 1
`define ACFG_B_ANTI 0

// Status field positions
`define ACFG_ST_BUSY_LSB 0
`define ACFG_ST_COMPRESS_LSB 4

// Field codes
`define ACFG_DECIM_RESERVED 2'h3
`define ACFG_AVG_OFF 2'h0
`define ACFG_AVG_ON 2'h1
`define ACFG_HPF_CUSTOM 2'h0
`define ACFG_VOL_MUTE 8'h00
`define ACFG_VOL_ZERO_DB 8'hC9

// Timing
`define ACFG_CLK_PERIOD_NS 50
`define ACFG_STEP_TIME_NS 1000
`define ACFG_STEP_CYCLES ((`ACFG_STEP_TIME_NS + `ACFG_CLK_PERIOD_NS - 1) / `ACFG_CLK_PERIOD_NS)

`endif

//--- core/acfg_pkg.sv
package acfg_pkg;

	typedef enum logic [1:0] {
		ACFG_DECIM_LINEAR,
		ACFG_DECIM_LOW_LATENCY,
		ACFG_DECIM_ULTRA_LOW,
		ACFG_DECIM_RESERVED
	} acfg_decim_t;

	typedef enum logic [1:0] {
		ACFG_HPF_CUSTOM_IIR,
		ACFG_HPF_CUT_00025,
		ACFG_HPF_CUT_002,
		ACFG_HPF_CUT_008
	} acfg_hpf_t;

	typedef struct packed {
		logic runtime_volume_lock;
		acfg_decim_t decimation_response_sel;
		logic decim_code_reserved;
		logic channel_average_enable;
		logic average_code_reserved;
		acfg_hpf_t highpass_select;
		logic highpass_custom_allpass;
	} acfg_cfg_a_t;

	typedef struct packed {
		logic volume_shared_from_first;
		logic [1:0] biquad_count;
		logic soft_step_enable;
		logic auto_level_select;
		logic anti_clip_enable;
	} acfg_cfg_b_t;

	typedef struct packed {
		logic mute;
		logic [8:0] gain_half_db;
	} acfg_vol_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [31:0] adr;
		logic [31:0] dat;
	} acfg_wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} acfg_wb_rsp_t;

endpackage

//--- core/acfg_vol_stepper.sv
`timescale 1ns/100ps
`include "acfg_defines.svh"

module acfg_vol_stepper #(
	parameter int STEP_CYCLES = `ACFG_STEP_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Control
	input wire logic [7:0] target,
	input wire logic accept,
	input wire logic soft_step,
	// State
	output logic [7:0] applied,
	output logic busy
);

	localparam int CW = $clog2(STEP_CYCLES + 1);

	generate
		if (STEP_CYCLES < 1) begin : g_bad
			$error("STEP_CYCLES must be at least one");
		end
	endgenerate

	logic [CW-1:0] cnt_q;
	logic [7:0] applied_q;
	logic tick;

	assign tick = (cnt_q == '0);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (tick) begin
			cnt_q <= CW'(STEP_CYCLES - 1);
		end else begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	// Held while locked, jumps or ramps one half-dB code per tick otherwise
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			applied_q <= `ACFG_RST_VOLUME;
		end else if (accept && applied_q != target) begin
			if (!soft_step) begin
				applied_q <= target;
			end else if (tick) begin
				applied_q <= (applied_q > target) ? applied_q - 8'h01 : applied_q + 8'h01;
			end
		end
	end

	assign applied = applied_q;
	assign busy = (applied_q != target);

endmodule

//--- core/acfg_vol_decode.sv
`timescale 1ns/100ps
`include "acfg_defines.svh"

module acfg_vol_decode (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Code in, level out
	input wire logic [7:0] code,
	output acfg_pkg::acfg_vol_t level
);

	acfg_pkg::acfg_vol_t level_q;

	// Gain in half-dB steps relative to 0 dB
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= '0;
		end else begin
			level_q.mute <= (code == `ACFG_VOL_MUTE);
			level_q.gain_half_db <= {1'b0, code} - {1'b0, `ACFG_VOL_ZERO_DB};
		end
	end

	assign level = level_q;

endmodule

//--- core/acfg_dsp_config.sv
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps
`include "acfg_defines.svh"

module acfg_dsp_config #(
	parameter int CHANNELS = 2,
	parameter int STEP_CYCLES = `ACFG_STEP_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Wishbone slave
	input acfg_pkg::acfg_wb_req_t wb_req,
	output acfg_pkg::acfg_wb_rsp_t wb_rsp,
	// Converter and gain controller state
	input wire logic adc_powered,
	input wire logic [CHANNELS-1:0] agc_channel_enable,
	input wire logic [CHANNELS-1:0] channel_gain_above_0db,
	input wire logic [CHANNELS-1:0] level_over_threshold,
	// Processing configuration
	output acfg_pkg::acfg_cfg_a_t cfg_a,
	output acfg_pkg::acfg_cfg_b_t cfg_b,
	// Per-channel volume and level control
	output acfg_pkg::acfg_vol_t channel_level [CHANNELS],
	output logic [CHANNELS-1:0] volume_step_busy,
	output logic [CHANNELS-1:0] auto_level_active,
	output logic [CHANNELS-1:0] compress_level,
	output logic [CHANNELS-1:0] keep_programmed_gain
);

	generate
		if (CHANNELS < 1 || CHANNELS > 4) begin : g_bad_ch
			$error("CHANNELS must be between one and four");
		end
		if (STEP_CYCLES < 1) begin : g_bad_step
			$error("STEP_CYCLES must be at least one");
		end
	endgenerate

	// Reset release synchroniser
	logic rst_meta_q;
	logic rst_sync_q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 1'b0;
		end else begin
			rst_sync_q <= rst_meta_q;
		end
	end

	logic rst_s_n;
	assign rst_s_n = rst_sync_q;

	// Bus decode
	logic req;
	logic adr_ok;
	logic [7:0] idx;
	logic mapped;
	logic [31:0] rd_d;
	logic ack_q;
	logic [31:0] rdat_q;
	logic wr_en;

	assign req = wb_req.cyc && wb_req.stb;
	assign adr_ok = (wb_req.adr[31:10] == 22'h000000) && (wb_req.adr[1:0] == 2'h0);
	assign idx = wb_req.adr[9:2];
	// Write lands on the edge that the master sees ack
	assign wr_en = req && wb_req.we && ack_q && wb_req.sel[0] && mapped;

	// Register storage
	logic [7:0] cfg_a_q;
	logic [7:0] cfg_b_q;
	logic [7:0] vol_q [CHANNELS];
	logic [7:0] applied [CHANNELS];
	logic [7:0] status_d;
	logic [CHANNELS-1:0] compress_q;
	logic [CHANNELS-1:0] auto_level_q;

	always_comb begin
		status_d = 8'h00;
		for (int i = 0; i < CHANNELS; i++) begin
			status_d[`ACFG_ST_BUSY_LSB + i] = volume_step_busy[i];
			status_d[`ACFG_ST_COMPRESS_LSB + i] = compress_q[i];
		end
	end

	// Read mux; unmapped addresses answer with zero
	always_comb begin
		rd_d = 32'h00000000;
		mapped = 1'b0;
		if (adr_ok) begin
			if (idx == `ACFG_IDX_CONFIG_A) begin
				rd_d[7:0] = cfg_a_q;
				mapped = 1'b1;
			end
			if (idx == `ACFG_IDX_CONFIG_B) begin
				rd_d[7:0] = cfg_b_q;
				mapped = 1'b1;
			end
			if (idx == `ACFG_IDX_STATUS) begin
				rd_d[7:0] = status_d;
				mapped = 1'b1;
			end
			for (int i = 0; i < CHANNELS; i++) begin
				if (idx == `ACFG_IDX_VOL_BASE + 8'(i)) begin
					rd_d[7:0] = vol_q[i];
					mapped = 1'b1;
				end
				if (idx == `ACFG_IDX_APPLIED_BASE + 8'(i)) begin
					rd_d[7:0] = applied[i];
					mapped = 1'b1;
				end
			end
		end
	end

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req && !ack_q;
		end
	end

	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			rdat_q <= 32'h00000000;
		end else if (req && !ack_q) begin
			rdat_q <= rd_d;
		end
	end

	assign wb_rsp.ack = ack_q;
	assign wb_rsp.dat = rdat_q;

	// Processing configuration A, reserved bit stored as written
	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			cfg_a_q <= `ACFG_RST_CONFIG_A;
		end else if (wr_en && idx == `ACFG_IDX_CONFIG_A) begin
			cfg_a_q <= wb_req.dat[7:0];
		end
	end

	// Processing configuration B
	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			cfg_b_q <= `ACFG_RST_CONFIG_B;
		end else if (wr_en && idx == `ACFG_IDX_CONFIG_B) begin
			cfg_b_q <= wb_req.dat[7:0];
		end
	end

	// Volume codes, one register per channel
	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			for (int i = 0; i < CHANNELS; i++) begin
				vol_q[i] <= `ACFG_RST_VOLUME;
			end
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (wr_en && idx == `ACFG_IDX_VOL_BASE + 8'(i)) begin
					vol_q[i] <= wb_req.dat[7:0];
				end
			end
		end
	end

	// Field decode
	logic [1:0] decim_code;
	logic [1:0] avg_code;
	logic [1:0] hpf_code;
	logic volume_lock;
	logic accept_volume;
	logic soft_step;

	assign decim_code = cfg_a_q[`ACFG_A_DECIM_LSB +: 2];
	assign avg_code = cfg_a_q[`ACFG_A_AVG_LSB +: 2];
	assign hpf_code = cfg_a_q[`ACFG_A_HPF_LSB +: 2];
	assign volume_lock = cfg_a_q[`ACFG_A_LOCK];
	// Locked while powered: the last applied volume stands
	assign accept_volume = !(volume_lock && adc_powered);
	assign soft_step = !cfg_b_q[`ACFG_B_SOFT_DIS];

	assign cfg_a.runtime_volume_lock = volume_lock;
	assign cfg_a.decimation_response_sel = acfg_pkg::acfg_decim_t'(decim_code);
	assign cfg_a.decim_code_reserved = (decim_code == `ACFG_DECIM_RESERVED);
	assign cfg_a.channel_average_enable = (avg_code == `ACFG_AVG_ON);
	assign cfg_a.average_code_reserved = (avg_code != `ACFG_AVG_OFF) && (avg_code != `ACFG_AVG_ON);
	assign cfg_a.highpass_select = acfg_pkg::acfg_hpf_t'(hpf_code);
	assign cfg_a.highpass_custom_allpass = (hpf_code == `ACFG_HPF_CUSTOM);

	assign cfg_b.volume_shared_from_first = cfg_b_q[`ACFG_B_GANG];
	assign cfg_b.biquad_count = cfg_b_q[`ACFG_B_BIQ_LSB +: 2];
	assign cfg_b.soft_step_enable = soft_step;
	assign cfg_b.auto_level_select = cfg_b_q[`ACFG_B_AGC];
	assign cfg_b.anti_clip_enable = cfg_b_q[`ACFG_B_ANTI];

	// Per-channel volume path
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			logic [7:0] target;
			// Ganged: every channel follows the first; ungang: each channel follows its own
			assign target = cfg_b_q[`ACFG_B_GANG] ? vol_q[0] : vol_q[g];

			acfg_vol_stepper #(
				.STEP_CYCLES(STEP_CYCLES)
			) u_step (
				.clock(clock),
				.rst_n(rst_s_n),
				.target(target),
				.accept(accept_volume),
				.soft_step(soft_step),
				.applied(applied[g]),
				.busy(volume_step_busy[g])
			);

			acfg_vol_decode u_dec (
				.clock(clock),
				.rst_n(rst_s_n),
				.code(applied[g]),
				.level(channel_level[g])
			);
		end
	endgenerate

	// Auto level and anti-clip per channel
	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			auto_level_q <= '0;
		end else begin
			auto_level_q <= {CHANNELS{cfg_b_q[`ACFG_B_AGC]}} & agc_channel_enable;
		end
	end

	always_ff @(posedge clock or negedge rst_s_n) begin
		if (!rst_s_n) begin
			compress_q <= '0;
		end else begin
			compress_q <= {CHANNELS{cfg_b_q[`ACFG_B_ANTI]}} & channel_gain_above_0db
				& agc_channel_enable & level_over_threshold;
		end
	end

	assign auto_level_active = auto_level_q;
	assign compress_level = compress_q;
	assign keep_programmed_gain = ~compress_q;

endmodule

//--- verification/acfg_dsp_config_checker.sv
`timescale 1ns/100ps
module acfg_dsp_config_checker #(
	parameter int CHANNELS = 2
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Bus
	input acfg_pkg::acfg_wb_req_t wb_req,
	input acfg_pkg::acfg_wb_rsp_t wb_rsp,
	// State inputs
	input wire logic adc_powered,
	input wire logic [CHANNELS-1:0] agc_channel_enable,
	input wire logic [CHANNELS-1:0] channel_gain_above_0db,
	input wire logic [CHANNELS-1:0] level_over_threshold,
	// Outputs
	input acfg_pkg::acfg_cfg_a_t cfg_a,
	input acfg_pkg::acfg_cfg_b_t cfg_b,
	input acfg_pkg::acfg_vol_t channel_level [CHANNELS],
	input wire logic [CHANNELS-1:0] volume_step_busy,
	input wire logic [CHANNELS-1:0] auto_level_active,
	input wire logic [CHANNELS-1:0] compress_level,
	input wire logic [CHANNELS-1:0] keep_programmed_gain
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire logic frz = cfg_a.runtime_volume_lock && adc_powered;
	ack_on_time_a: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack) else $error("ack late");
	ack_single_a: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack too long");
	reset_values_a: assert property ($rose(rst_n) |-> cfg_b.biquad_count == 2'h2 && cfg_b.soft_step_enable
		&& cfg_a.highpass_select == acfg_pkg::ACFG_HPF_CUT_00025 && !cfg_a.runtime_volume_lock) else $error("bad reset");
	auto_level_a: assert property (auto_level_active ==
		$past({CHANNELS{cfg_b.auto_level_select}} & agc_channel_enable)) else $error("auto level wrong");
	compress_a: assert property (compress_level == $past({CHANNELS{cfg_b.anti_clip_enable}}
		& channel_gain_above_0db & agc_channel_enable & level_over_threshold)) else $error("compress wrong");
	keep_gain_a: assert property (keep_programmed_gain == ~$past({CHANNELS{cfg_b.anti_clip_enable}}
		& channel_gain_above_0db & agc_channel_enable & level_over_threshold)) else $error("keep gain wrong");
	lock_hold_a: assert property (frz |-> ##2 $stable(channel_level[CHANNELS-1])) else $error("volume moved");
	jump_step_a: assert property (!cfg_b.soft_step_enable && !frz && volume_step_busy[0] && !wb_rsp.ack
		|=> !volume_step_busy[0]) else $error("no jump");
	cover property (compress_level != '0);
	cover property (frz);
	cover property (volume_step_busy[0] && cfg_b.soft_step_enable);
endmodule

bind acfg_dsp_config acfg_dsp_config_checker #(.CHANNELS(CHANNELS)) u_chk (.clock(clock), .rst_n(rst_n),
	.wb_req(wb_req), .wb_rsp(wb_rsp), .adc_powered(adc_powered), .agc_channel_enable(agc_channel_enable),
	.channel_gain_above_0db(channel_gain_above_0db), .level_over_threshold(level_over_threshold),
	.cfg_a(cfg_a), .cfg_b(cfg_b), .channel_level(channel_level), .volume_step_busy(volume_step_busy),
	.auto_level_active(auto_level_active), .compress_level(compress_level),
	.keep_programmed_gain(keep_programmed_gain));

//--- verification/acfg_dsp_config_tb.sv
`timescale 1ns/100ps
module acfg_dsp_config_tb;
	localparam logic [31:0] A = 32'h1AC;
	localparam logic [31:0] B = 32'h1B0;
	localparam logic [31:0] V = 32'h200;
	localparam logic [31:0] ST = 32'h220;
	localparam logic [31:0] AP = 32'h240;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	acfg_pkg::acfg_wb_req_t wb_req = '0;
	acfg_pkg::acfg_wb_rsp_t wb_rsp;
	logic adc_powered = 1'b0;
	logic [1:0] agc_en = '0;
	logic [1:0] gain_hi = '0;
	logic [1:0] over = '0;
	acfg_pkg::acfg_cfg_a_t cfg_a;
	acfg_pkg::acfg_cfg_b_t cfg_b;
	acfg_pkg::acfg_vol_t lvl [2];
	logic [1:0] busy, auto_on, comp, keep;
	logic [7:0] codes [4] = '{8'h00, 8'h01, 8'hC9, 8'hFF};
	logic [31:0] rd;
	int fail_count = 0;
	int check_count = 0;
	int cycles = 0;

	initial forever #25 clock = ~clock;

	acfg_dsp_config #(.CHANNELS(2), .STEP_CYCLES(2)) DUT (.clock(clock), .rst_n(rst_n), .wb_req(wb_req),
		.wb_rsp(wb_rsp), .adc_powered(adc_powered), .agc_channel_enable(agc_en), .channel_gain_above_0db(gain_hi),
		.level_over_threshold(over), .cfg_a(cfg_a), .cfg_b(cfg_b), .channel_level(lvl), .volume_step_busy(busy),
		.auto_level_active(auto_on), .compress_level(comp), .keep_programmed_gain(keep));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			end_of_test();
		end
	end

	task automatic ck(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
		int n;
		n = 0;
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: {24'h0, d}};
		do begin
			@(posedge clock);
			n++;
		end while (wb_rsp.ack !== 1'b1);
		ck("ack", n, 2);
		rd = wb_rsp.dat;
		wb_req <= '0;
		@(posedge clock);
	endtask

	task automatic rdck(input string n, input logic [31:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		ck(n, rd, {24'h0, e});
	endtask

	function automatic logic [31:0] g(input logic [7:0] c);
		return {23'h0, {1'b0, c} - 9'd201};
	endfunction

	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		rdck("cfg_a", A, 8'h01);
		rdck("cfg_b", B, 8'h40);
		rdck("vol0", V, 8'hC9);
		ck("biquads", cfg_b.biquad_count, 2'h2);
		ck("hpf", cfg_a.highpass_select, 2'h1);
		$display("reset test done");
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, A, {2'b00, 2'(k), 2'(k), 2'(k)});
			rdck("a_back", A, {2'b00, 2'(k), 2'(k), 2'(k)});
			ck("decim", cfg_a.decimation_response_sel, k);
			ck("decim_rsv", cfg_a.decim_code_reserved, k == 3);
			ck("avg", cfg_a.channel_average_enable, k == 1);
			ck("avg_rsv", cfg_a.average_code_reserved, k > 1);
			ck("highpass_select", cfg_a.highpass_select, k);
			ck("allpass", cfg_a.highpass_custom_allpass, k == 0);
			bus(1'b1, B, {k[0], 2'(k), k[0], k[1], 2'b00, k[0]});
			ck("gang", cfg_b.volume_shared_from_first, k[0]);
			ck("biq", cfg_b.biquad_count, k);
			ck("soft_en", cfg_b.soft_step_enable, !k[0]);
			ck("agc", cfg_b.auto_level_select, k[1]);
			ck("anti", cfg_b.anti_clip_enable, k[0]);
		end
		bus(1'b1, 32'h3FC, 8'hAA);
		rdck("unmapped", 32'h3FC, 8'h00);
		rdck("misaligned", 32'h1AD, 8'h00);
		bus(1'b1, ST, 8'hFF);
		rdck("status_ro", ST, 8'h00);
		$display("field test done");
		adc_powered <= 1'b1;
		bus(1'b1, B, 8'h10);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, V, codes[i]);
			repeat (3) @(posedge clock);
			ck("mute", lvl[0].mute, codes[i] == 8'h00);
			if (codes[i] != 8'h00) ck("gain", {23'h0, lvl[0].gain_half_db}, g(codes[i]));
			rdck("applied", AP, codes[i]);
		end
		bus(1'b1, B, 8'h40);
		bus(1'b1, V, 8'hF5);
		bus(1'b0, AP, 8'h00);
		ck("stepping", rd[7:0] > 8'hF5, 1'b1);
		rdck("busy", ST, 8'h01);
		for (int n = 0; n < 100 && busy[0] !== 1'b0; n++) @(posedge clock);
		ck("settled", busy[0], 1'b0);
		rdck("stepped", AP, 8'hF5);
		$display("volume test done");
		bus(1'b1, B, 8'h90);
		bus(1'b1, V, 8'h10);
		bus(1'b1, V + 4, 8'h80);
		repeat (3) @(posedge clock);
		ck("gang_on", {23'h0, lvl[1].gain_half_db}, g(8'h10));
		bus(1'b1, B, 8'h10);
		repeat (3) @(posedge clock);
		ck("gang_off", {23'h0, lvl[1].gain_half_db}, g(8'h80));
		bus(1'b1, A, 8'h81);
		bus(1'b1, V + 4, 8'h20);
		repeat (3) @(posedge clock);
		ck("locked", {23'h0, lvl[1].gain_half_db}, g(8'h80));
		rdck("vol1", V + 4, 8'h20);
		adc_powered <= 1'b0;
		repeat (4) @(posedge clock);
		ck("unlocked", {23'h0, lvl[1].gain_half_db}, g(8'h20));
		$display("gang and lock test done");
		agc_en <= 2'b11;
		gain_hi <= 2'b01;
		over <= 2'b11;
		bus(1'b1, B, 8'h19);
		@(posedge clock);
		ck("auto", auto_on, 2'b11);
		ck("comp", comp, 2'b01);
		ck("keep", keep, 2'b10);
		rdck("st_comp", ST, 8'h10);
		over <= 2'b10;
		agc_en <= 2'b10;
		repeat (2) @(posedge clock);
		ck("comp_thr", comp, 2'b00);
		ck("auto_en", auto_on, 2'b10);
		over <= 2'b11;
		agc_en <= 2'b11;
		bus(1'b1, B, 8'h10);
		@(posedge clock);
		ck("keep_off", keep, 2'b11);
		$display("level control test done");
		end_of_test();
	end
endmodule
